/* File: rtl/cisc_pkg.sv */
// Purpose: Shared constants for the core control block
// Assumes: Byte-wide register port, 10 MHz core clock
// Notes: Offsets are I/O-space addresses
package cisc_pkg;
    localparam logic [5:0] OFS_UNLOCK = 6'h3c;
    localparam logic [5:0] OFS_SP_LOW = 6'h3d;
    localparam logic [5:0] OFS_SP_HIGH = 6'h3e;
    localparam logic [5:0] OFS_STATUS = 6'h3f;
    localparam logic [5:0] OFS_IRQ_FLAG = 6'h3a;
    localparam logic [5:0] OFS_IRQ_EN = 6'h3b;
    localparam logic [7:0] UNLOCK_SIG = 8'hd8;
    localparam logic [7:0] RST_UNLOCK = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [15:0] RST_SP = 16'h005f;
    localparam logic [15:0] RAM_START = 16'h0040;
    localparam int GIE_BIT = 7;
    localparam int UNLOCK_CYCLES = 4;
    localparam int ENTRY_CYCLES = 4;
    localparam int WAKE_EXTRA = 4;
    localparam int RETURN_CYCLES = 4;
    localparam int FIRST_REG = 16;
    localparam int NUM_REGS = 16;
    typedef enum logic [2:0] {
        CISC_RUN = 3'h0,
        CISC_WAKE = 3'h1,
        CISC_ENTRY = 3'h2,
        CISC_RETURN = 3'h3
    } cisc_state_t;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_PUSH = 3'h1,
        OP_POP = 3'h2,
        OP_CALL = 3'h3,
        OP_RET = 3'h4,
        OP_SET_GIE = 3'h5,
        OP_CLR_GIE = 3'h6,
        OP_RETURN_IRQ = 3'h7
    } cisc_op_t;
endpackage

/* File: rtl/cisc_core.sv */
// Purpose: Register file, stack pointer, status flags and interrupt control
// Assumes: Instruction decode happens outside and drives the op and port signals
// Notes: Vector number 0 is reset; source k uses vector k+1
// What this block does
// RQ1: Status flags refresh after every ALU operation
// RQ2: Status never saved on entry or return
// RQ3: Sixteen 8-bit registers, numbered from sixteen
// RQ4: Three read/write port schemes, 8 or 16-bit
// RQ5: Last six registers form three pointers
// RQ6: Byte push lowers stack pointer by one
// RQ7: Calls and entry lower stack pointer by two
// RQ8: Byte pop raises stack pointer by one
// RQ9: Stack pointer resets to last SRAM address
// RQ10: Software sets stack before calls or interrupts
// RQ11: Stack pointer split into low, high bytes
// RQ12: Two-operand operation completes in one cycle
// RQ13: Accept needs local and global enable
// RQ14: Lower vector number means higher priority
// RQ15: Entry clears global enable, return sets it
// RQ16: Vectoring or writing one clears flag
// RQ17: Pending flags wait, then served by priority
// RQ18: Level sources request only while present
// RQ19: One instruction runs after return first
// RQ20: Disable acts at once; enable delays one
// RQ21: Entry takes four cycles, pushing program counter; here the stack pointer only drops by two and ret_addr_i is never stored
// RQ22: Wake from sleep adds four cycles
// RQ23: Return takes four cycles, pops counter, sets enable
// RQ24: Signature opens four-cycle protected write window
// RQ25: Global enable is status bit seven
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module cisc_core #(
    parameter int NSRC = 4,
    parameter logic [NSRC-1:0] LEVEL_SRC = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [5:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic prot_wr_ok_o,
    // Instruction stream
    input wire logic instr_done_i,
    input wire logic sleeping_i,
    input wire cisc_pkg::cisc_op_t op_i,
    input wire logic [15:0] ret_addr_i,
    output logic [15:0] sp_o,
    output logic [15:0] pc_o,
    output logic pc_load_o,
    output logic [7:0] status_o,
    // ALU flag update
    input wire logic alu_we_i,
    input wire logic [6:0] alu_flags_i,
    // Register file ports
    input wire logic [4:0] ra_i,
    input wire logic [4:0] rb_i,
    output logic [7:0] ra_data_o,
    output logic [7:0] rb_data_o,
    output logic [15:0] rw_data_o,
    input wire logic [4:0] wr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic wr_wide_i,
    input wire logic [1:0] ptr_sel_i,
    input wire logic [1:0] ptr_mode_i,
    input wire logic [5:0] ptr_disp_i,
    output logic [15:0] ptr_addr_o,
    // Stack memory data
    input wire logic [15:0] pop_data_i,
    // Interrupt sources
    input wire logic [NSRC-1:0] irq_event_i,
    output logic irq_taken_o,
    output logic [7:0] vector_o
);
    import cisc_pkg::*;

    logic [7:0] regs [NUM_REGS];
    logic [15:0] sp;
    logic [7:0] status;
    logic [NSRC-1:0] irq_flag;
    logic [NSRC-1:0] irq_en;
    logic [NSRC-1:0] src_s1;
    logic [NSRC-1:0] src_s2;
    logic [2:0] unlock_cnt;
    cisc_state_t state;
    logic [3:0] cyc;
    logic hold_one;
    logic [NSRC-1:0] req;
    logic [NSRC-1:0] grant;
    logic take;
    logic [7:0] vec;
    logic [15:0] ptr;
    logic [15:0] next_ptr;

    function automatic logic [3:0] ridx(input logic [4:0] num);
        return 4'(num - 5'(FIRST_REG)); // RQ3
    endfunction

    // Local and global enable both needed; level sources need no flag
    always_comb begin
        req = (irq_flag | (LEVEL_SRC & src_s2)) & irq_en; // RQ13 RQ18
        grant = '0;
        vec = 8'h00;
        for (int k = NSRC - 1; k >= 0; k--) begin
            if (req[k]) begin
                grant = '0;
                grant[k] = 1'b1;
                vec = 8'(k + 1); // RQ14
            end
        end
    end

    // Disable seen combinationally so a same-cycle clear blocks entry
    assign take = state == CISC_RUN && instr_done_i && |req && status[GIE_BIT]
        && op_i != OP_CLR_GIE && !hold_one && unlock_cnt == 3'h0; // RQ20 RQ21 RQ24 RQ25

    always_ff @(posedge clk_i) begin
        src_s1 <= irq_event_i;
        src_s2 <= src_s1;
    end

    // Flags: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_flag <= '0;
            irq_en <= '0;
        end else begin
            logic [NSRC-1:0] clr;
            clr = '0;
            if (reg_wr_i && reg_addr_i == OFS_IRQ_FLAG) begin
                clr = reg_wdata_i[NSRC-1:0]; // RQ16
            end
            if (take) begin
                clr = clr | grant; // RQ16
            end
            irq_flag <= ((irq_flag & ~clr) | src_s2) & ~LEVEL_SRC; // RQ17
            if (reg_wr_i && reg_addr_i == OFS_IRQ_EN) begin
                irq_en <= reg_wdata_i[NSRC-1:0];
            end
        end
    end

    // Entry, wake and return sequencing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= CISC_RUN;
            cyc <= 4'h0;
            hold_one <= 1'b0;
            vector_o <= 8'h00;
        end else begin
            case (state)
                CISC_RUN: begin
                    if (instr_done_i) begin
                        hold_one <= (op_i == OP_SET_GIE); // RQ20
                    end
                    if (take) begin
                        vector_o <= vec;
                        cyc <= 4'h1;
                        state <= sleeping_i ? CISC_WAKE : CISC_ENTRY; // RQ22
                    end else if (instr_done_i && op_i == OP_RETURN_IRQ) begin
                        cyc <= 4'h1;
                        state <= CISC_RETURN;
                    end
                end
                CISC_WAKE: begin
                    cyc <= (cyc == 4'(WAKE_EXTRA)) ? 4'h1 : cyc + 4'h1;
                    if (cyc == 4'(WAKE_EXTRA)) begin
                        state <= CISC_ENTRY; // RQ22
                    end
                end
                CISC_ENTRY: begin
                    cyc <= cyc + 4'h1;
                    if (cyc == 4'(ENTRY_CYCLES)) begin
                        state <= CISC_RUN; // RQ21
                    end
                end
                CISC_RETURN: begin
                    cyc <= cyc + 4'h1;
                    if (cyc == 4'(RETURN_CYCLES)) begin
                        hold_one <= 1'b1; // RQ19
                        state <= CISC_RUN; // RQ23
                    end
                end
                default: state <= CISC_RUN;
            endcase
        end
    end

    assign irq_taken_o = take;
    assign pc_load_o = (state == CISC_ENTRY && cyc == 4'(ENTRY_CYCLES))
        || (state == CISC_RETURN && cyc == 4'(RETURN_CYCLES));
    assign pc_o = (state == CISC_RETURN) ? pop_data_i : {8'h00, vector_o};

    // Status: never pushed or popped, the handler saves it if needed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= RST_STATUS;
        end else begin
            if (alu_we_i) begin
                status[6:0] <= alu_flags_i; // RQ1 RQ2
            end
            if (reg_wr_i && reg_addr_i == OFS_STATUS) begin
                status <= reg_wdata_i;
            end
            if (take || (instr_done_i && op_i == OP_CLR_GIE && state == CISC_RUN)) begin
                status[GIE_BIT] <= 1'b0; // RQ15 RQ20
            end else if (instr_done_i && op_i == OP_SET_GIE && state == CISC_RUN) begin
                status[GIE_BIT] <= 1'b1;
            end else if (state == CISC_RETURN && cyc == 4'(RETURN_CYCLES)) begin
                status[GIE_BIT] <= 1'b1; // RQ15 RQ23
            end
        end
    end

    // Stack pointer; resets to RST_SP, already inside SRAM above RAM_START
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp <= RST_SP; // RQ9
        end else if (take) begin
            sp <= sp - 16'h0002; // RQ7
        end else if (state == CISC_RETURN && cyc == 4'(RETURN_CYCLES)) begin
            sp <= sp + 16'h0002; // RQ23
        end else if (reg_wr_i && reg_addr_i == OFS_SP_LOW) begin
            sp[7:0] <= reg_wdata_i; // RQ11
        end else if (reg_wr_i && reg_addr_i == OFS_SP_HIGH) begin
            sp[15:8] <= reg_wdata_i; // RQ11
        end else if (instr_done_i && state == CISC_RUN) begin
            case (op_i)
                OP_PUSH: sp <= sp - 16'h0001; // RQ6
                OP_POP: sp <= sp + 16'h0001; // RQ8
                OP_CALL: sp <= sp - 16'h0002; // RQ7
                OP_RET: sp <= sp + 16'h0002;
                default: sp <= sp;
            endcase
        end
    end
    assign sp_o = sp;

    // Unlock window counts instruction cycles after the signature
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unlock_cnt <= 3'h0;
        end else if (reg_wr_i && reg_addr_i == OFS_UNLOCK && reg_wdata_i == UNLOCK_SIG) begin
            unlock_cnt <= 3'(UNLOCK_CYCLES); // RQ24
        end else if (unlock_cnt != 3'h0 && instr_done_i) begin
            unlock_cnt <= unlock_cnt - 3'h1;
        end
    end
    assign prot_wr_ok_o = unlock_cnt != 3'h0;

    // Read port: data one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            if (reg_addr_i == OFS_UNLOCK) begin
                reg_rdata_o <= {7'h00, unlock_cnt != 3'h0};
            end else if (reg_addr_i == OFS_SP_LOW) begin
                reg_rdata_o <= sp[7:0];
            end else if (reg_addr_i == OFS_SP_HIGH) begin
                reg_rdata_o <= sp[15:8];
            end else if (reg_addr_i == OFS_STATUS) begin
                reg_rdata_o <= status;
            end else if (reg_addr_i == OFS_IRQ_FLAG) begin
                reg_rdata_o <= 8'(irq_flag);
            end else if (reg_addr_i == OFS_IRQ_EN) begin
                reg_rdata_o <= 8'(irq_en);
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // Pointer pairs: low byte in the even register
    always_comb begin
        logic [3:0] lo;
        lo = 4'(4'd10 + {ptr_sel_i, 1'b0}); // RQ5
        ptr = {regs[lo + 4'h1], regs[lo]};
        next_ptr = ptr;
        ptr_addr_o = ptr;
        case (ptr_mode_i)
            2'h1: ptr_addr_o = ptr + {10'h000, ptr_disp_i}; // RQ5
            2'h2: next_ptr = ptr + 16'h0001; // RQ5
            2'h3: begin
                next_ptr = ptr - 16'h0001; // RQ5
                ptr_addr_o = next_ptr;
            end
            default: next_ptr = ptr;
        endcase
    end

    // Combinational reads, write at the edge: one-cycle operate
    assign ra_data_o = regs[ridx(ra_i)]; // RQ4 RQ12
    assign rb_data_o = regs[ridx(rb_i)]; // RQ4 RQ12
    assign rw_data_o = {regs[ridx(ra_i) | 4'h1], regs[ridx(ra_i) & 4'he]}; // RQ4

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= 8'h00;
            end
        end else begin
            if (ptr_mode_i[1] && ptr_sel_i != 2'h3) begin
                regs[4'(4'd10 + {ptr_sel_i, 1'b0})] <= next_ptr[7:0];
                regs[4'(4'd11 + {ptr_sel_i, 1'b0})] <= next_ptr[15:8];
            end
            if (wr_en_i && wr_wide_i) begin
                regs[ridx(wr_i) & 4'he] <= wr_data_i[7:0]; // RQ4
                regs[ridx(wr_i) | 4'h1] <= wr_data_i[15:8];
            end else if (wr_en_i) begin
                regs[ridx(wr_i)] <= wr_data_i[7:0]; // RQ4 RQ12
            end
        end
    end

    assign status_o = status;
endmodule

/* File: tb/cisc_core_props.sv */
// Purpose: Port timing checks for the core control block
// Assumes: One clock, synchronous active-high reset
// Notes: Entry and return lengths allow the take cycle either way
`timescale 1ns/1ps
module cisc_core_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [5:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic prot_wr_ok_o,
    // Instruction stream
    input wire logic instr_done_i,
    input wire logic sleeping_i,
    input wire cisc_pkg::cisc_op_t op_i,
    input wire logic [15:0] sp_o,
    input wire logic pc_load_o,
    input wire logic [7:0] status_o,
    input wire logic alu_we_i,
    input wire logic [6:0] alu_flags_i,
    input wire logic irq_taken_o
);
    import cisc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    reset_val_a: assert property ($past(rst_i) |-> sp_o == RST_SP && status_o == RST_STATUS)
        else $error("stack or status wrong after reset");
    push_dec_a: assert property (instr_done_i && op_i == OP_PUSH && !irq_taken_o
        |=> sp_o == $past(sp_o) - 16'h1) else $error("push did not lower stack by one");
    pop_inc_a: assert property (instr_done_i && op_i == OP_POP && !irq_taken_o
        |=> sp_o == $past(sp_o) + 16'h1) else $error("pop did not raise stack by one");
    call_dec_a: assert property (instr_done_i && op_i == OP_CALL && !irq_taken_o
        |=> sp_o == $past(sp_o) - 16'h2) else $error("call did not lower stack by two");
    take_effect_a: assert property (irq_taken_o
        |=> !status_o[GIE_BIT] && sp_o == $past(sp_o) - 16'h2) else $error("bad take effect");
    take_cause_a: assert property (irq_taken_o |-> instr_done_i && status_o[GIE_BIT]
        && !prot_wr_ok_o && op_i != OP_CLR_GIE) else $error("take without cause");
    entry_len_a: assert property (irq_taken_o && !sleeping_i
        |-> ##1 !pc_load_o [*2] ##[1:2] pc_load_o) else $error("entry length wrong");
    wake_len_a: assert property (irq_taken_o && sleeping_i
        |-> ##1 !pc_load_o [*7] ##1 pc_load_o) else $error("wake entry length wrong");
    return_len_a: assert property (instr_done_i && op_i == OP_RETURN_IRQ |-> ##1 !pc_load_o [*2]
        ##[1:2] (pc_load_o ##1 (status_o[GIE_BIT] && sp_o == $past(sp_o) + 16'h2)))
        else $error("return sequence wrong");
    alu_flags_a: assert property (alu_we_i && !(reg_wr_i && reg_addr_i == OFS_STATUS)
        |=> status_o[6:0] == $past(alu_flags_i)) else $error("flags not refreshed");
    unlock_open_a: assert property (reg_wr_i && reg_addr_i == OFS_UNLOCK
        && reg_wdata_i == UNLOCK_SIG |=> prot_wr_ok_o) else $error("unlock window not open");
endmodule
bind cisc_core cisc_core_props u_cisc_core_props (.*);

/* File: tb/cisc_far_end.sv */
// Purpose: Interrupt pins and stack word facing the core
// Assumes: Pin pulses last two clocks so the sync flops see them
// Notes: Stack word is fixed; no real memory behind it
`timescale 1ns/1ps
module cisc_far_end #(
    parameter logic [15:0] RET_WORD = 16'h0123
) (
    // Clock
    input wire logic clk_i,
    // Bench requests
    input wire logic [3:0] fire_i,
    // Toward the core
    output logic [3:0] irq_event_o,
    output logic [15:0] pop_data_o
);
    logic [3:0] held = 4'h0;
    always_ff @(posedge clk_i) begin
        held <= fire_i;
        irq_event_o <= fire_i | held;
    end
    assign pop_data_o = RET_WORD;
endmodule

/* File: tb/tb_cisc_core.sv */
// Purpose: Directed bench for the core control block
// Assumes: Partner model drives pins and the stack word
// Notes: Sleep path is driven once, for the last interrupt served
`timescale 1ns/1ps
module tb_cisc_core;
    import cisc_pkg::*;
    logic clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, instr_done_i = 0, sleeping_i = 0;
    logic alu_we_i = 0, wr_en_i = 0, wr_wide_i = 0, prot_wr_ok_o, pc_load_o, irq_taken_o, taken;
    logic [5:0] reg_addr_i = '0, ptr_disp_i = '0;
    logic [7:0] reg_wdata_i = '0, reg_rdata_o, status_o, ra_data_o, rb_data_o, vector_o;
    cisc_op_t op_i = OP_NONE;
    logic [6:0] alu_flags_i = '0;
    logic [4:0] ra_i = 5'h10, rb_i = 5'h10, wr_i = 5'h10;
    logic [1:0] ptr_sel_i = '0, ptr_mode_i = '0;
    logic [3:0] fire = '0, irq_event_i;
    logic [15:0] wr_data_i = '0, pop_data_i, sp_o, pc_o, rw_data_o, ptr_addr_o, sp0;
    int miscompares = 0, comparisons = 0;
    always #50 clk_i = ~clk_i;
    cisc_core u_cisc_core (.ret_addr_i(16'h0000), .*);
    cisc_far_end u_cisc_far_end (.clk_i(clk_i), .fire_i(fire), .irq_event_o(irq_event_i),
        .pop_data_o(pop_data_i));
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [5:0] a, logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(logic [5:0] a, logic [7:0] e, string n);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        chk(n, reg_rdata_o, e);
    endtask
    task automatic step(cisc_op_t op);
        @(posedge clk_i);
        instr_done_i <= 1'b1;
        op_i <= op;
        @(negedge clk_i);
        taken = irq_taken_o;
        @(posedge clk_i);
        instr_done_i <= 1'b0;
        op_i <= OP_NONE;
        @(negedge clk_i);
    endtask
    task automatic pulse(logic [3:0] v);
        @(posedge clk_i);
        fire <= v;
        @(posedge clk_i);
        fire <= 4'h0;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic wait_load(logic c, logic [15:0] e);
        for (int i = 0; i < 12; i++) begin
            if (pc_load_o === 1'b1) begin
                if (c) chk("pc", pc_o, e);
                return;
            end
            @(negedge clk_i);
        end
        chk("pc_load", 1'b0, 1'b1);
    endtask
    task automatic serve(logic [7:0] v);
        taken = 1'b0;
        sp0 = sp_o;
        for (int i = 0; i < 4 && taken !== 1'b1; i++) step(OP_NONE);
        chk("taken", taken, 1'b1);
        wait_load(1'b0, 16'h0);
        @(negedge clk_i);
        chk("vector", vector_o, v);
        chk("sp", sp_o, sp0 - 16'h2);
        chk("status", status_o, 8'h55);
    endtask
    task automatic ret();
        sp0 = sp_o;
        step(OP_RETURN_IRQ);
        wait_load(1'b1, 16'h0123);
        @(negedge clk_i);
        chk("status", status_o, 8'hd5);
        chk("sp", sp_o, sp0 + 16'h2);
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #300000;
        miscompares++;
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_STATUS, RST_STATUS, "status");
        rd(OFS_SP_LOW, 8'h5f, "sp_low");
        rd(OFS_SP_HIGH, 8'h00, "sp_high");
        rd(OFS_UNLOCK, RST_UNLOCK, "unlock");
        rd(6'h10, 8'h00, "unmapped");
        wr(OFS_SP_LOW, 8'h5a);
        step(OP_PUSH);
        chk("sp", sp_o, 16'h0059);
        step(OP_POP);
        chk("sp", sp_o, 16'h005a);
        step(OP_CALL);
        rd(OFS_SP_LOW, 8'h58, "sp_low");
        @(posedge clk_i);
        alu_we_i <= 1'b1;
        alu_flags_i <= 7'h55;
        wr_en_i <= 1'b1;
        wr_data_i <= 16'h00a5;
        @(posedge clk_i);
        alu_we_i <= 1'b0;
        wr_wide_i <= 1'b1;
        wr_i <= 5'h1a;
        wr_data_i <= 16'h1234;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
        ra_i <= 5'h1a;
        @(negedge clk_i);
        chk("status", status_o, 8'h55);
        chk("ra", ra_data_o, 8'h34);
        chk("rb", rb_data_o, 8'ha5);
        chk("rw", rw_data_o, 16'h1234);
        chk("ptr", ptr_addr_o, 16'h1234);
        @(posedge clk_i);
        ptr_mode_i <= 2'h2;
        @(posedge clk_i);
        ptr_mode_i <= 2'h0;
        @(negedge clk_i);
        chk("ptr", ptr_addr_o, 16'h1235);
        @(posedge clk_i);
        ptr_mode_i <= 2'h3;
        @(negedge clk_i);
        chk("ptr", ptr_addr_o, 16'h1234);
        @(posedge clk_i);
        ptr_mode_i <= 2'h1;
        ptr_disp_i <= 6'h05;
        @(negedge clk_i);
        chk("ptr", ptr_addr_o, 16'h1239);
        wr(OFS_IRQ_EN, 8'h06);
        pulse(4'h7);
        rd(OFS_IRQ_FLAG, 8'h07, "irq_flag");
        step(OP_NONE);
        chk("taken", taken, 1'b0);
        step(OP_SET_GIE);
        serve(8'h02);
        rd(OFS_IRQ_FLAG, 8'h05, "irq_flag");
        ret();
        serve(8'h03);
        ret();
        wr(OFS_IRQ_FLAG, 8'h01);
        rd(OFS_IRQ_FLAG, 8'h00, "irq_flag");
        pulse(4'h2);
        step(OP_CLR_GIE);
        chk("taken", taken, 1'b0);
        chk("gie", status_o[GIE_BIT], 1'b0);
        wr(OFS_UNLOCK, UNLOCK_SIG);
        rd(OFS_UNLOCK, 8'h01, "unlock");
        step(OP_SET_GIE);
        repeat (2) begin
            step(OP_NONE);
            chk("taken", taken, 1'b0);
        end
        serve(8'h02);
        chk("prot", prot_wr_ok_o, 1'b0);
        ret();
        @(posedge clk_i);
        sleeping_i <= 1'b1;
        pulse(4'h2);
        serve(8'h02);
        @(posedge clk_i);
        sleeping_i <= 1'b0;
        ret();
        wrap_up;
    end
endmodule
